// >>> hw/bwmpc_pkg.sv
// Constants, types and helpers for the bandwidth minimum and portion bitmap
// configuration bank. Assumes a single 250 MHz clock and a simple
// one-request-per-cycle register port.
// Notes on behaviour
// - Minimum bandwidth register kept as four separate copies, one per security frame.
// - Portion bitmap array kept as four separate copies, one per security frame.
// - Minimum bandwidth register decoded at 0x0200 in every frame, read/write.
// - Bitmap word n decoded at 0x2000 plus four times n in every frame.
// - Root and realm copies are reachable only when the realm feature exists.
// - With instance select, accesses reach the selected instance and partition.
// - Without instance select, accesses reach the selected partition only.
// - Internal flag must match narrowing presence; software sets it accordingly.
// - Portion p lives in word p[11:5], bit p[4:0].
// - Bitmap bit zero forbids allocation in a portion, one permits it.
// - Bitmap width lies between one and 4096 portions.
// - Bitmaps over 32 portions span successive words, at most 128 words.
// - Words above the width's upper bits are wholly reserved and read zero.
// - In the boundary word, bits from width[4:0] upward are reserved.
// - Minimum is an unsigned fraction in bits 15:0, point above bit 15.
// - A partition using less than its minimum gets preferential access.
package bwmpc_pkg;
   localparam int ADDR_W = 14;
   localparam int PID_W = 2;
   localparam int RIS_W = 1;
   localparam logic [13:0] OFF_PSEL = 14'h0100;
   localparam logic [13:0] OFF_MIN = 14'h0200;
   localparam logic [13:0] OFF_PBM_BASE = 14'h2000;
   localparam int PBM_MAX_REGS = 128;
   localparam int PSEL_PID_LSB = 0;
   localparam int PSEL_INTERNAL_BIT = 16;
   localparam int PSEL_RIS_LSB = 24;
   // Bitmap width field value, implemented minimum width and feature straps
   localparam logic [12:0] PBM_WD = 13'h0028;
   localparam logic [15:0] MIN_IMPL_MASK = 16'hfff0;
   localparam logic [15:0] MIN_RESET = 16'h0000;
   localparam logic [31:0] PBM_RESET = 32'h00000000;
   localparam logic [31:0] PSEL_RESET = 32'h00000000;
   localparam logic REALM_PRESENT = 1'b1;
   localparam logic HAS_INSTANCE_SELECT = 1'b1;
   localparam logic NARROWING = 1'b0;
   localparam int PBM_WORDS = (int'(PBM_WD) + 31) / 32;
   localparam logic [6:0] PBM_WORDS_N = 7'(PBM_WORDS);
   localparam int PBM_WORD_W = (PBM_WORDS > 1) ? $clog2(PBM_WORDS) : 1;
   localparam int KEY_W = 2 + RIS_W + PID_W;
   localparam int COMBOS = 1 << KEY_W;

   typedef enum logic [1:0] {
      SPACE_SECURE = 2'b00,
      SPACE_NONSECURE = 2'b01,
      SPACE_ROOT = 2'b10,
      SPACE_REALM = 2'b11
   } bwmpc_space_t;

   typedef struct packed {
      logic write;
      bwmpc_space_t space;
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } bwmpc_req_t;

   typedef struct packed {
      bwmpc_space_t space;
      logic [RIS_W-1:0] resource_instance_select;
      logic [PID_W-1:0] pid;
   } bwmpc_key_t;

   typedef struct packed {
      logic [RIS_W-1:0] resource_instance_select;
      logic internal;
      logic [PID_W-1:0] pid;
   } bwmpc_psel_t;

   typedef struct packed {
      bwmpc_key_t key;
      logic [15:0] usage;
      logic [11:0] portion;
   } bwmpc_query_t;

   function automatic logic [KEY_W-1:0] key_index(input bwmpc_key_t k);
      return {k.space, k.resource_instance_select, k.pid};
   endfunction

   // Valid bits of bitmap word n; a width of 4096 leaves every word valid
   function automatic logic [31:0] pbm_valid_mask(input logic [6:0] n);
      if (PBM_WD[12] || (n < PBM_WD[11:5])) begin
         return 32'hffffffff;
      end else if (n == PBM_WD[11:5]) begin
         return (32'h00000001 << PBM_WD[4:0]) - 32'h00000001;
      end else begin
         return 32'h00000000;
      end
   endfunction
endpackage

// >>> hw/bwmpc_store.sv
// Settings storage: minimum fraction and bitmap words per space, instance and
// partition. Assumes writers have already masked reserved bits.
`timescale 1ns/1ps
module bwmpc_store (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_wr_min,
   input wire logic i_wr_pbm,
   input wire logic [bwmpc_pkg::KEY_W-1:0] i_key,
   input wire logic [bwmpc_pkg::PBM_WORD_W-1:0] i_word,
   input wire logic [31:0] i_wdata,
   output logic [15:0] o_min,
   output logic [31:0] o_pbm,
   input wire logic [bwmpc_pkg::KEY_W-1:0] i_qkey,
   input wire logic [bwmpc_pkg::PBM_WORD_W-1:0] i_qword,
   output logic [15:0] o_qmin,
   output logic [31:0] o_qpbm
);
   logic [15:0] min_mem [bwmpc_pkg::COMBOS];
   logic [31:0] pbm_mem [bwmpc_pkg::COMBOS * bwmpc_pkg::PBM_WORDS];

   // One slot per key keeps every combination independent
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         for (int i = 0; i < bwmpc_pkg::COMBOS; i++) begin
            min_mem[i] <= bwmpc_pkg::MIN_RESET;
         end
      end else if (i_wr_min) begin
         min_mem[i_key] <= i_wdata[15:0];
      end
   end

   // Words beyond the implemented width are never stored
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         for (int i = 0; i < bwmpc_pkg::COMBOS * bwmpc_pkg::PBM_WORDS; i++) begin
            pbm_mem[i] <= bwmpc_pkg::PBM_RESET;
         end
      end else if (i_wr_pbm) begin
         pbm_mem[{i_key, i_word}] <= i_wdata;
      end
   end

   assign o_min = min_mem[i_key];
   assign o_pbm = pbm_mem[{i_key, i_word}];
   assign o_qmin = min_mem[i_qkey];
   assign o_qpbm = pbm_mem[{i_qkey, i_qword}];
endmodule // bwmpc_store

// >>> hw/bwmpc_top.sv
// Register bank for the minimum bandwidth fraction and portion bitmap, four
// security frames deep. Assumes one request per cycle, answered the next cycle,
// and a regulator that queries the stored settings each cycle.
`timescale 1ns/1ps
module bwmpc_top (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_req,
   input wire bwmpc_pkg::bwmpc_req_t i_req_data,
   output logic o_ready,
   output logic [31:0] o_rdata,
   input wire bwmpc_pkg::bwmpc_query_t i_query,
   output logic o_preferred,
   output logic o_permit
);
   bwmpc_pkg::bwmpc_psel_t psel [4];
   bwmpc_pkg::bwmpc_psel_t sel;
   bwmpc_pkg::bwmpc_key_t key;
   logic realm_ok;
   logic id_ok;
   logic is_psel;
   logic is_min;
   logic is_pbm;
   logic [6:0] pbm_n;
   logic pbm_stored;
   logic [31:0] pbm_mask;
   logic wr_min;
   logic wr_pbm;
   logic wr_psel;
   logic [31:0] store_wdata;
   logic [15:0] st_min;
   logic [31:0] st_pbm;
   logic [15:0] q_min;
   logic [31:0] q_pbm;
   logic q_in_range;
   logic [31:0] next_rdata;

   always_comb begin
      sel = psel[i_req_data.space];
      key.space = i_req_data.space;
      key.pid = sel.pid;
      key.resource_instance_select = bwmpc_pkg::HAS_INSTANCE_SELECT ? sel.resource_instance_select : '0;
      realm_ok = !i_req_data.space[1] || bwmpc_pkg::REALM_PRESENT;
      id_ok = (sel.internal == bwmpc_pkg::NARROWING);
      is_psel = (i_req_data.addr == bwmpc_pkg::OFF_PSEL);
      is_min = (i_req_data.addr == bwmpc_pkg::OFF_MIN);
      is_pbm = (i_req_data.addr[13:9] == bwmpc_pkg::OFF_PBM_BASE[13:9]) && (i_req_data.addr[1:0] == 2'b00);
      pbm_n = i_req_data.addr[8:2];
      pbm_stored = (pbm_n < bwmpc_pkg::PBM_WORDS_N);
      pbm_mask = bwmpc_pkg::pbm_valid_mask(pbm_n);
   end

   // Frame selects the copy; absent frames ignore writes, mismatched flags ignore minimum and bitmap writes
   assign wr_psel = i_req && i_req_data.write && is_psel && realm_ok;
   assign wr_min = i_req && i_req_data.write && is_min && realm_ok && id_ok;
   assign wr_pbm = i_req && i_req_data.write && is_pbm && pbm_stored && realm_ok && id_ok;
   assign store_wdata = is_min ? {16'h0000, i_req_data.wdata[15:0] & bwmpc_pkg::MIN_IMPL_MASK}
                               : (i_req_data.wdata & pbm_mask);

   bwmpc_store i_bwmpc_store (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_wr_min(wr_min),
      .i_wr_pbm(wr_pbm),
      .i_key(bwmpc_pkg::key_index(key)),
      .i_word(pbm_n[bwmpc_pkg::PBM_WORD_W-1:0]),
      .i_wdata(store_wdata),
      .o_min(st_min),
      .o_pbm(st_pbm),
      .i_qkey(bwmpc_pkg::key_index(i_query.key)),
      .i_qword(i_query.portion[5+bwmpc_pkg::PBM_WORD_W-1:5]),
      .o_qmin(q_min),
      .o_qpbm(q_pbm)
   );

   // One select per frame, so frames never steer each other
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         for (int i = 0; i < 4; i++) begin
            psel[i].pid <= bwmpc_pkg::PSEL_RESET[bwmpc_pkg::PSEL_PID_LSB +: bwmpc_pkg::PID_W];
            psel[i].internal <= bwmpc_pkg::PSEL_RESET[bwmpc_pkg::PSEL_INTERNAL_BIT];
            psel[i].resource_instance_select <= bwmpc_pkg::PSEL_RESET[bwmpc_pkg::PSEL_RIS_LSB +: bwmpc_pkg::RIS_W];
         end
      end else if (wr_psel) begin
         psel[i_req_data.space].pid <= i_req_data.wdata[bwmpc_pkg::PSEL_PID_LSB +: bwmpc_pkg::PID_W];
         psel[i_req_data.space].internal <= i_req_data.wdata[bwmpc_pkg::PSEL_INTERNAL_BIT];
         psel[i_req_data.space].resource_instance_select <= i_req_data.wdata[bwmpc_pkg::PSEL_RIS_LSB +: bwmpc_pkg::RIS_W];
      end
   end

   always_comb begin
      next_rdata = 32'h00000000;
      if (i_req && !i_req_data.write && realm_ok) begin
         if (is_psel) begin
            next_rdata[bwmpc_pkg::PSEL_PID_LSB +: bwmpc_pkg::PID_W] = sel.pid;
            next_rdata[bwmpc_pkg::PSEL_INTERNAL_BIT] = sel.internal;
            next_rdata[bwmpc_pkg::PSEL_RIS_LSB +: bwmpc_pkg::RIS_W] = sel.resource_instance_select;
         end else if (is_min && id_ok) begin
            next_rdata[15:0] = st_min;
         end else if (is_pbm && pbm_stored && id_ok) begin
            next_rdata = st_pbm & pbm_mask;
         end
      end
   end

   // Every access completes in one cycle, mapped or not
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_ready <= 1'b0;
         o_rdata <= 32'h00000000;
      end else begin
         o_ready <= i_req;
         o_rdata <= next_rdata;
      end
   end

   // Word range check guards a narrow index from aliasing a high portion
   assign q_in_range = (7'(i_query.portion[11:5]) < bwmpc_pkg::PBM_WORDS_N);

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_preferred <= 1'b0;
         o_permit <= 1'b0;
      end else begin
         o_preferred <= i_query.usage < q_min;
         o_permit <= q_in_range && q_pbm[i_query.portion[4:0]];
      end
   end

   // Helper state seen only by the checks below
   logic rd_min;
   logic rd_pbm;
   logic rd_hit;
   logic rd_gated;
   logic [6:0] rd_n;
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         rd_min <= 1'b0;
         rd_pbm <= 1'b0;
         rd_hit <= 1'b0;
         rd_gated <= 1'b0;
         rd_n <= 7'h00;
      end else begin
         rd_min <= i_req && !i_req_data.write && is_min;
         rd_pbm <= i_req && !i_req_data.write && is_pbm;
         rd_hit <= i_req && (is_min || is_pbm || is_psel);
         rd_gated <= i_req && !realm_ok;
         rd_n <= pbm_n;
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   a_ready_follows: assert property (i_req |=> o_ready) else $error("request not answered");
   a_ready_idle: assert property (!i_req |=> !o_ready) else $error("spurious ready");
   a_min_upper: assert property (rd_min |-> o_rdata[31:16] == 16'h0000
      && (o_rdata[15:0] & ~bwmpc_pkg::MIN_IMPL_MASK) == 16'h0000)
      else $error("min reserved bits set");
   a_realm_gate: assert property (rd_gated |-> o_rdata == 32'h00000000) else $error("absent frame read nonzero");
   a_pbm_reserved: assert property (rd_pbm && !bwmpc_pkg::PBM_WD[12] && rd_n > bwmpc_pkg::PBM_WD[11:5]
      |-> o_rdata == 32'h0)
      else $error("reserved bitmap word nonzero");
   a_pbm_partial: assert property (rd_pbm |-> (o_rdata & ~bwmpc_pkg::pbm_valid_mask(rd_n)) == 32'h0)
      else $error("reserved bitmap bits nonzero");
   a_unmapped_zero: assert property (o_ready && !rd_hit |-> o_rdata == 32'h0) else $error("unmapped read nonzero");
   a_min_roundtrip: assert property (wr_min ##1 (i_req && !i_req_data.write && is_min
      && i_req_data.space == $past(i_req_data.space))
      |=> o_rdata[15:0] == ($past(i_req_data.wdata[15:0], 2) & bwmpc_pkg::MIN_IMPL_MASK))
      else $error("min readback mismatch");
   // A portion past the stored words must not alias onto a low word
   a_permit_range: assert property (7'(i_query.portion[11:5]) >= bwmpc_pkg::PBM_WORDS_N |=> !o_permit)
      else $error("permit beyond bitmap width");
   a_pref_zero_min: assert property (q_min == 16'h0000 |=> !o_preferred) else $error("preferred with zero min");

   c_min_write: cover property (wr_min ##1 i_req && is_min);
   c_pbm_write: cover property (wr_psel ##[1:4] wr_pbm);
   c_permit: cover property (o_permit);
   c_preferred: cover property (o_preferred);
endmodule // bwmpc_top

// >>> verification/bwmpc_top_tb_top.sv
// Self-checking bench for the bandwidth minimum and portion bitmap bank.
// Assumes the package straps; a model in the bench mirrors every stored setting.
`timescale 1ns/1ps
module bwmpc_top_tb_top;
   logic i_clock;
   logic i_rst_n;
   logic i_req;
   bwmpc_pkg::bwmpc_req_t i_req_data;
   bwmpc_pkg::bwmpc_query_t i_query;
   logic o_ready;
   logic [31:0] o_rdata;
   logic o_preferred;
   logic o_permit;
   logic q_go;
   logic q_chk;
   logic [31:0] exp_q[$];
   logic [1:0] qexp_q[$];
   logic [31:0] psel [4];
   logic [15:0] mins [32];
   logic [31:0] pbm [32][128];
   int n_fail;
   int num_checks;
   logic [13:0] addrs [8] = '{14'h0100, 14'h0200, 14'h2000, 14'h2004, 14'h2008, 14'h21fc, 14'h0204, 14'h0208};

   bwmpc_top i_bwmpc_top (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(i_req), .i_req_data(i_req_data),
      .o_ready(o_ready), .o_rdata(o_rdata), .i_query(i_query), .o_preferred(o_preferred), .o_permit(o_permit));

   initial begin
      i_clock = 1'b0;
      forever #2 i_clock = ~i_clock;
   end

   // Valid bits of bitmap word n, worked out from the width alone
   function automatic logic [31:0] vmask(input int n);
      int wd;
      wd = int'(bwmpc_pkg::PBM_WD);
      if (wd >= 32 * (n + 1)) return 32'hffffffff;
      if (wd <= 32 * n) return 32'h00000000;
      return (32'h00000001 << (wd - 32 * n)) - 32'h00000001;
   endfunction

   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Request stays up between calls so back-to-back accesses really happen
   task automatic acc(input logic wr, input logic [1:0] sp, input logic [13:0] ad, input logic [31:0] wd);
      logic [4:0] k;
      logic sl;
      logic live;
      logic [31:0] r;
      @(posedge i_clock);
      i_req <= 1'b1;
      i_req_data <= '{write: wr, space: bwmpc_pkg::bwmpc_space_t'(sp), addr: ad, wdata: wd};
      k = {sp, psel[sp][24], psel[sp][1:0]};
      sl = (sp < 2'd2) || bwmpc_pkg::REALM_PRESENT;
      live = sl && (psel[sp][16] == bwmpc_pkg::NARROWING);
      r = 32'h00000000;
      if (sl && ad == bwmpc_pkg::OFF_PSEL) begin
         if (wr) psel[sp] = wd & 32'h01010003;
         r = psel[sp];
      end else if (live && ad == bwmpc_pkg::OFF_MIN) begin
         if (wr) mins[k] = wd[15:0] & bwmpc_pkg::MIN_IMPL_MASK;
         r = {16'h0000, mins[k]};
      end else if (live && ad[13:9] == 5'h10 && ad[1:0] == 2'b00) begin
         if (wr) pbm[k][ad[8:2]] = wd & vmask(int'(ad[8:2]));
         r = pbm[k][ad[8:2]];
      end
      exp_q.push_back(wr ? 32'h00000000 : r);
   endtask

   task automatic qry(input logic [4:0] k, input logic [15:0] u, input logic [11:0] p);
      @(posedge i_clock);
      q_go <= 1'b1;
      i_query <= '{key: '{space: bwmpc_pkg::bwmpc_space_t'(k[4:3]), resource_instance_select: k[2], pid: k[1:0]}, usage: u, portion: p};
      qexp_q.push_back({u < mins[k], pbm[k][p[11:5]][p[4:0]]});
   endtask

   task automatic drain();
      int i;
      @(posedge i_clock);
      i_req <= 1'b0;
      q_go <= 1'b0;
      for (i = 0; i < 50 && (exp_q.size() + qexp_q.size()) > 0; i++) @(posedge i_clock);
      if (exp_q.size() + qexp_q.size() > 0) begin
         n_fail++;
         complete_run();
      end
   endtask

   task automatic do_reset();
      i_rst_n <= 1'b0;
      foreach (psel[i]) psel[i] = 32'h00000000;
      foreach (mins[i]) mins[i] = 16'h0000;
      foreach (pbm[i, j]) pbm[i][j] = 32'h00000000;
      repeat (20) @(posedge i_clock);
      i_rst_n <= 1'b1;
   endtask

   // Query answers land on the same edge that samples the query, one edge after it is driven
   always @(posedge i_clock) q_chk <= q_go;

   // Sampled mid-cycle so registered answers have settled
   always @(negedge i_clock) begin
      if (o_ready === 1'b1) begin
         if (exp_q.size() == 0) check("ready", 32'h0, 32'h1);
         else check("rdata", exp_q.pop_front(), o_rdata);
      end
      if (q_chk === 1'b1) begin
         if (qexp_q.size() == 0) check("query", 32'h0, 32'h1);
         else check("query", {30'h0, qexp_q.pop_front()}, {30'h0, o_preferred, o_permit});
      end
   end

   initial begin
      repeat (5000) @(posedge i_clock);
      n_fail++;
      complete_run();
   end

   initial begin
      logic [31:0] v;
      int i;
      i_rst_n = 1'b0;
      i_req = 1'b0;
      i_req_data = '0;
      i_query = '0;
      q_go = 1'b0;
      n_fail = 0;
      num_checks = 0;
      v = $urandom(32'h198a);
      // Second pass starts with a reset in mid-run, so cleared settings are seen again
      repeat (2) begin
         do_reset();
         for (i = 0; i < 4; i++) begin
            acc(1'b0, 2'(i), bwmpc_pkg::OFF_MIN, 32'h0);
            acc(1'b0, 2'(i), bwmpc_pkg::OFF_PBM_BASE, 32'h0);
            acc(1'b1, 2'(i), bwmpc_pkg::OFF_PSEL, $urandom & 32'h01000003);
            acc(1'b1, 2'(i), bwmpc_pkg::OFF_MIN, 32'hffffffff);
            acc(1'b0, 2'(i), bwmpc_pkg::OFF_MIN, 32'h0);
            acc(1'b1, 2'(i), 14'h2004, 32'hffffffff);
            acc(1'b0, 2'(i), 14'h2004, 32'h0);
            acc(1'b1, 2'(i), 14'h2008, 32'hffffffff);
            acc(1'b0, 2'(i), 14'h2008, 32'h0);
            acc(1'b0, 2'(i), 14'h21fc, 32'h0);
         end
         // Random selects mix instance, partition and internal flag with every register
         repeat (300) acc(1'($urandom), 2'($urandom), addrs[3'($urandom)], $urandom);
         drain();
         repeat (200) begin
            v = $urandom;
            qry(5'(v), 16'($urandom), v[5] ? 12'(v[31:26]) : v[31:20]);
         end
         drain();
      end
      complete_run();
   end
endmodule // bwmpc_top_tb_top
